// File: hw/cmst_ctrl.sv
// Mode select, communication status and transmit buffer control of a CAN
// controller, with an APB register slave. Assumes the frame engine on the
// same clock supplies error counts, queue levels and per-buffer events.
// Overview of operation
// - Two-bit functional mode: 00 legacy (reset), 01 enhanced legacy, 10 queue.
// - Functional mode field only writable while in configuration mode.
// - Three-bit operating mode status: 100 config, 011 listen, 010 loop, 000 normal.
// - Queue mode only: queue interrupt at one free (watermark 1) or four free.
// - Queues of four or fewer buffers still raise the low-watermark interrupt.
// - Five-bit extended map select picks the banked group shown in the window.
// - Modes 1, 2: codes map tx, rx, configurable, rx-int groups; zero in mode 0.
// - Legacy map select sits at control bits 3:1, aligned with interrupt code.
// - Mode 0: sticky bit 7 set on receive buffer 0 overrun, software cleared.
// - Mode 2: bit 7 shows queue not empty; reads zero in mode 1.
// - Sticky bit 6 on overrun: buffer 1 in mode 0, any buffer otherwise.
// - Transmitter bus-off bit while transmit error count exceeds 255.
// - Transmitter passive bit while transmit error count exceeds 127.
// - Receiver passive bit while receive error count exceeds 127.
// - Transmitter warning bit while transmit error count exceeds 95.
// - Receiver warning bit while receive count above 95 and at most 127.
// - Combined warning bit 0 is OR of receiver and transmitter warnings.
// - Done flag bit 7 set on completion; read-only mode 0, clearable otherwise.
// - Read-only aborted, arbitration-lost and bus-error status bits per buffer.
// - Writing request 1 schedules the buffer and clears its three status bits.
// - Request bit cleared by hardware after a successful send.
// - Pending buffer is read-only; clearing its request asks for an abort (its done flag still clears by software in modes 1, 2).
// - Two-bit buffer priority orders pending buffers, 11 highest.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps

module cmst_ctrl
  import cmst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frame engine status
  input wire logic modeSwitchOk,
  input wire logic [8:0] txErrCount,
  input wire logic [7:0] rxErrCount,
  input wire logic [4:0] interruptSourceCode,
  input wire logic [3:0] rxQueueCount,
  input wire logic [3:0] rxQueueFree,
  input wire logic rxOverrun0,
  input wire logic rxOverrun1,
  input wire logic rxOverrunAny,
  input wire cmst_txev_t txEvents,
  // Control toward the frame engine
  output logic [2:0] operatingModeStatus,
  output logic [1:0] functionalModeSelect,
  output logic [2:0] txPending,
  output logic [2:0] txAbortRequest,
  output logic txSelValid,
  output logic [1:0] txSelect,
  output logic rxQueueIrq,
  output cmst_win_t accessWindow
);

  cmst_state_t q, d;
  logic [7:0] commStat;
  logic wrStb, rdSetup;

  // Pick highest priority pending buffer, ties to the higher number
  function automatic logic [2:0] pickTx(input logic [2:0] pend,
                                        input logic [5:0] pri);
    logic [2:0] res;
    logic [1:0] best;
    res = 3'h0;
    best = 2'h0;
    for (int i = 0; i < 3; i++) begin
      if (pend[i] && (!res[2] || pri[2*i+:2] >= best)) begin
        res = {1'b1, 2'(i)};
        best = pri[2*i+:2];
      end
    end
    return res;
  endfunction

  // Decode the window selection into a kind and index
  function automatic cmst_win_t mapWindow(input logic [1:0] fm,
                                          input logic [4:0] ext,
                                          input logic [2:0] leg);
    cmst_win_t w;
    w = '{kind: WK_OTHER, index: 3'h0};
    if (fm == FM_LEGACY) begin
      case (leg)
        3'h4: w = '{kind: WK_TX, index: 3'h0};
        3'h3: w = '{kind: WK_TX, index: 3'h1};
        3'h2: w = '{kind: WK_TX, index: 3'h2};
        3'h5: w = '{kind: WK_RX, index: 3'h1};
        default: w = '{kind: WK_RX, index: 3'h0};
      endcase
    end else if (ext >= EW_TX0 && ext <= EW_TX2) begin
      w = '{kind: WK_TX, index: 3'(ext - EW_TX0)};
    end else if (ext == EW_RX0 || ext == EW_RX1) begin
      w = '{kind: WK_RX, index: 3'(ext - EW_RX0)};
    end else if (ext >= EW_CFG0 && ext <= EW_CFG5) begin
      w = '{kind: WK_CFGBUF, index: 3'(ext - EW_CFG0)};
    end else if (ext == EW_RXINT) begin
      w = '{kind: WK_RXINT, index: 3'h0};
    end
    return w;
  endfunction

  // Communication status, bits 5:0 live from the error counters, bits 7:6 from the overrun flags or queue level
  always_comb begin
    commStat = 8'h00;
    commStat[5] = txErrCount > TEC_BUSOFF_LIM;
    commStat[4] = txErrCount > TEC_PASSIVE_LIM;
    commStat[3] = rxErrCount > REC_PASSIVE_LIM;
    commStat[2] = txErrCount > TEC_WARN_LIM;
    commStat[1] = rxErrCount > REC_WARN_LIM &&
                  rxErrCount <= REC_PASSIVE_LIM;
    commStat[0] = commStat[1] | commStat[2];
    commStat[6] = q.ovf1;
    case (q.modeSel)
      FM_LEGACY: commStat[7] = q.ovf0;
      FM_ENH_QUEUE: commStat[7] = rxQueueCount != 4'h0;
      default: commStat[7] = 1'b0;
    endcase
  end

  // APB strobes: writes land at the access edge, reads prepared in setup
  assign wrStb = psel && penable && pwrite && pstrb[0];
  assign rdSetup = psel && !penable;

  // Next-state logic for the whole block
  always_comb begin
    d = q;
    // Register writes
    if (wrStb) begin
      case (paddr)
        ADDR_CTRL: begin
          d.reqMode = pwdata[7:5];
          d.legMap = pwdata[3:1];
        end
        ADDR_MAPCTL: begin
          if (q.operating_mode_status == OPM_CONFIG && pwdata[7:6] != 2'h3) begin
            d.modeSel = pwdata[7:6];
          end
          d.wm = pwdata[5];
          d.extMap = pwdata[4:0];
        end
        ADDR_COMMUNICATION_ERROR_STATUS: begin
          if (!pwdata[7]) begin
            d.ovf0 = 1'b0;
          end
          if (!pwdata[6]) begin
            d.ovf1 = 1'b0;
          end
        end
        default: ;
      endcase
      for (int i = 0; i < 3; i++) begin
        if (paddr == ADDR_TXCON0 + 12'(4 * i)) begin
          if (q.modeSel != FM_LEGACY && !pwdata[TXC_DONE]) begin
            d.txDone[i] = 1'b0;
          end
          if (q.tx_send_request[i]) begin
            if (!pwdata[TXC_REQ]) begin
              d.txAbortReq[i] = 1'b1;
            end
          end else begin
            d.tx_buffer_priority[2*i+:2] = pwdata[1:0];
            if (pwdata[TXC_REQ]) begin
              d.tx_send_request[i] = 1'b1;
              d.tx_aborted_status[i] = 1'b0;
              d.tx_arbitration_lost_status[i] = 1'b0;
              d.tx_bus_fault_status[i] = 1'b0;
            end
          end
        end
      end
    end
    // Hardware events win over software clears
    if (q.modeSel == FM_LEGACY) begin
      if (rxOverrun0) begin
        d.ovf0 = 1'b1;
      end
      if (rxOverrun1) begin
        d.ovf1 = 1'b1;
      end
    end else if (rxOverrunAny) begin
      d.ovf1 = 1'b1;
    end
    for (int i = 0; i < 3; i++) begin
      if (q.tx_send_request[i]) begin
        if (txEvents.arbLost[i]) begin
          d.tx_arbitration_lost_status[i] = 1'b1;
        end
        if (txEvents.busErr[i]) begin
          d.tx_bus_fault_status[i] = 1'b1;
        end
        if (txEvents.aborted[i]) begin
          d.tx_aborted_status[i] = 1'b1;
          d.tx_send_request[i] = 1'b0;
          d.txAbortReq[i] = 1'b0;
        end
        if (txEvents.done[i]) begin
          d.txDone[i] = 1'b1;
          d.tx_send_request[i] = 1'b0;
          d.txAbortReq[i] = 1'b0;
        end
      end
    end
    // Operating mode follows the request once the engine allows it
    if (modeSwitchOk && q.reqMode <= OPM_CONFIG) begin
      d.operating_mode_status = q.reqMode;
    end
    // Transmit selection and access window
    {d.txSelValid, d.txSel} = pickTx(q.tx_send_request & ~q.txAbortReq, q.tx_buffer_priority);
    d.legacy_map_select = mapWindow(q.modeSel, q.extMap, q.legMap);
    // Read data prepared during the setup phase
    d.slverr = 1'b0;
    if (rdSetup) begin
      d.rdata = 32'h0000_0000;
      case (paddr)
        ADDR_CTRL: begin
          d.rdata[7:5] = q.reqMode;
          if (q.modeSel == FM_LEGACY) begin
            d.rdata[3:1] = q.legMap;
          end
        end
        ADDR_STAT: begin
          d.rdata[7:5] = q.operating_mode_status;
          if (q.modeSel == FM_LEGACY) begin
            d.rdata[3:1] = interruptSourceCode[3:1];
          end else begin
            d.rdata[4:0] = interruptSourceCode;
          end
        end
        ADDR_MAPCTL: begin
          d.rdata[7:5] = {q.modeSel, q.wm};
          if (q.modeSel != FM_LEGACY) begin
            d.rdata[4:0] = q.extMap;
          end
        end
        ADDR_COMMUNICATION_ERROR_STATUS: d.rdata[7:0] = commStat;
        ADDR_TXCON0, ADDR_TXCON1, ADDR_TXCON2: begin
          for (int i = 0; i < 3; i++) begin
            if (paddr == ADDR_TXCON0 + 12'(4 * i)) begin
              d.rdata[7:0] = {q.txDone[i], q.tx_aborted_status[i], q.tx_arbitration_lost_status[i],
                              q.tx_bus_fault_status[i], q.tx_send_request[i], 1'b0,
                              q.tx_buffer_priority[2*i+:2]};
            end
          end
        end
        default: d.slverr = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
      q.reqMode <= OPM_CONFIG;
      q.operating_mode_status <= OPM_CONFIG;
      q.modeSel <= FM_LEGACY;
      q.extMap <= EXT_MAP_RESET;
      q.legMap <= LEG_MAP_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = q.slverr && psel && penable;
  assign operatingModeStatus = q.operating_mode_status;
  assign functionalModeSelect = q.modeSel;
  assign txPending = q.tx_send_request;
  assign txAbortRequest = q.txAbortReq;
  assign txSelValid = q.txSelValid;
  assign txSelect = q.txSel;
  assign accessWindow = q.legacy_map_select;
  // Queue interrupt, level while free space is at or below the mark
  assign rxQueueIrq = q.modeSel == FM_ENH_QUEUE &&
      rxQueueFree <= (q.wm ? WM_HIGH_FREE : WM_LOW_FREE);

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_mode_sel_lock: assert property (
    $changed(q.modeSel) |-> $past(q.operating_mode_status) == OPM_CONFIG)
    else $error("mode select changed outside config mode");
  a_mode_sel_legal: assert property (
    q.modeSel != 2'h3)
    else $error("reserved mode select value");
  a_busoff_read: assert property (
    rdSetup && paddr == ADDR_COMMUNICATION_ERROR_STATUS |=>
      prdata[5] == ($past(txErrCount) > 9'h0FF))
    else $error("bus-off bit wrong on read");
  a_rx_warn_band: assert property (
    commStat[1] |-> rxErrCount inside {[8'h60:8'h7F]})
    else $error("receiver warning outside band");
  a_warn_combined: assert property (
    rdSetup && paddr == ADDR_COMMUNICATION_ERROR_STATUS |=> prdata[0] == (prdata[1] | prdata[2]))
    else $error("combined warning mismatch");
  a_tx_done_clr: assert property (
    q.tx_send_request[0] && txEvents.done[0] |=> !q.tx_send_request[0] && q.txDone[0])
    else $error("request not cleared on completion");
  a_req_clears_st: assert property (
    wrStb && paddr == ADDR_TXCON0 && pwdata[3] && !q.tx_send_request[0] |=>
      q.tx_send_request[0] && !q.tx_aborted_status[0] && !q.tx_arbitration_lost_status[0] && !q.tx_bus_fault_status[0])
    else $error("request write did not clear status");
  a_abort_req: assert property (
    wrStb && paddr == ADDR_TXCON1 && !pwdata[3] && q.tx_send_request[1] |=>
      q.txAbortReq[1] && $stable(q.tx_buffer_priority[3:2]))
    else $error("clearing pending request did not abort");
  a_tie_pick: assert property (
    q.tx_send_request[2:1] == 2'h3 && q.txAbortReq == 3'h0 &&
    q.tx_buffer_priority[3:2] == q.tx_buffer_priority[5:4] &&
    (!q.tx_send_request[0] || q.tx_buffer_priority[1:0] <= q.tx_buffer_priority[5:4]) |=>
      txSelValid && txSelect == 2'h2)
    else $error("tie not broken toward higher buffer");
  a_ovf_sticky: assert property (
    q.ovf0 && !(wrStb && paddr == ADDR_COMMUNICATION_ERROR_STATUS) |=> q.ovf0)
    else $error("overrun flag lost without clear");
  a_queue_irq: assert property (
    rxQueueIrq |-> q.modeSel == FM_ENH_QUEUE && rxQueueFree <= 4'h4)
    else $error("queue interrupt outside queue mode");
  a_ext_map_zero: assert property (
    rdSetup && paddr == ADDR_MAPCTL && q.modeSel == FM_LEGACY |=>
      prdata[4:0] == 5'h00)
    else $error("extended map visible in legacy mode");
  // Threshold bits as seen on a status read
  a_tx_passive: assert property (
    rdSetup && paddr == ADDR_COMMUNICATION_ERROR_STATUS |=>
      prdata[4] == ($past(txErrCount) > 9'h07F))
    else $error("transmitter passive bit wrong on read");
  a_rx_passive: assert property (
    rdSetup && paddr == ADDR_COMMUNICATION_ERROR_STATUS |=>
      prdata[3] == ($past(rxErrCount) > 8'h7F))
    else $error("receiver passive bit wrong on read");
  a_tx_warn: assert property (
    rdSetup && paddr == ADDR_COMMUNICATION_ERROR_STATUS |=>
      prdata[2] == ($past(txErrCount) > 9'h05F))
    else $error("transmitter warning bit wrong on read");
  // Buffer status flags
  a_done_clear: assert property (
    wrStb && paddr == ADDR_TXCON0 && !pwdata[7] &&
    q.modeSel != FM_LEGACY && !txEvents.done[0] |=> !q.txDone[0])
    else $error("done flag not cleared by software");
  a_abort_sets: assert property (
    q.tx_send_request[1] && txEvents.aborted[1] |=> q.tx_aborted_status[1] && !q.tx_send_request[1])
    else $error("abort event not recorded");
  // Receive status in the enhanced modes
  a_queue_flag: assert property (
    rdSetup && paddr == ADDR_COMMUNICATION_ERROR_STATUS && q.modeSel == FM_ENH_LEGACY |=>
      !prdata[7])
    else $error("queue flag visible in mode 1");
  a_ovf_any: assert property (
    q.modeSel != FM_LEGACY && rxOverrunAny |=> q.ovf1)
    else $error("overrun in enhanced mode not flagged");

  c_tx_done: cover property (q.tx_send_request[2] ##1 !q.tx_send_request[2] && q.txDone[2]);
  c_abort: cover property (q.txAbortReq[0] ##[1:20] q.tx_aborted_status[0]);
  c_queue_mode: cover property (q.modeSel == FM_ENH_QUEUE && rxQueueIrq);
  c_busoff: cover property (commStat[5]);
  c_tie: cover property (q.tx_send_request == 3'h6 && q.tx_buffer_priority[3:2] == q.tx_buffer_priority[5:4]);

endmodule // cmst_ctrl

// File: hw/cmst_pkg.sv
// Package for the CAN mode, status and transmit-buffer control block.
// Assumes a single clock domain and an APB register slave.
package cmst_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_MAPCTL = 12'h008;
  localparam logic [11:0] ADDR_COMMUNICATION_ERROR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_TXCON0 = 12'h010;
  localparam logic [11:0] ADDR_TXCON1 = 12'h014;
  localparam logic [11:0] ADDR_TXCON2 = 12'h018;
  // Functional modes
  localparam logic [1:0] FM_LEGACY = 2'h0;
  localparam logic [1:0] FM_ENH_LEGACY = 2'h1;
  localparam logic [1:0] FM_ENH_QUEUE = 2'h2;
  // Operating mode status codes
  localparam logic [2:0] OPM_NORMAL = 3'h0;
  localparam logic [2:0] OPM_SLEEP = 3'h1;
  localparam logic [2:0] OPM_LOOPBACK = 3'h2;
  localparam logic [2:0] OPM_LISTEN = 3'h3;
  localparam logic [2:0] OPM_CONFIG = 3'h4;
  // Reset values
  localparam logic [4:0] EXT_MAP_RESET = 5'h10;
  localparam logic [2:0] LEG_MAP_RESET = 3'h0;
  // Error counter thresholds
  localparam logic [8:0] TEC_BUSOFF_LIM = 9'h0FF;
  localparam logic [8:0] TEC_PASSIVE_LIM = 9'h07F;
  localparam logic [8:0] TEC_WARN_LIM = 9'h05F;
  localparam logic [7:0] REC_PASSIVE_LIM = 8'h7F;
  localparam logic [7:0] REC_WARN_LIM = 8'h5F;
  // Receive queue watermarks, buffers left free
  localparam logic [3:0] WM_HIGH_FREE = 4'h1;
  localparam logic [3:0] WM_LOW_FREE = 4'h4;
  // Transmit buffer control field positions
  localparam int TXC_DONE = 7;
  localparam int TXC_ABT = 6;
  localparam int TXC_LARB = 5;
  localparam int TXC_ERR = 4;
  localparam int TXC_REQ = 3;
  // Window decode kinds
  localparam logic [2:0] WK_OTHER = 3'h0;
  localparam logic [2:0] WK_TX = 3'h1;
  localparam logic [2:0] WK_RX = 3'h2;
  localparam logic [2:0] WK_CFGBUF = 3'h3;
  localparam logic [2:0] WK_RXINT = 3'h4;
  localparam logic [4:0] EW_TX0 = 5'h03;
  localparam logic [4:0] EW_TX2 = 5'h05;
  localparam logic [4:0] EW_RXINT = 5'h0F;
  localparam logic [4:0] EW_RX0 = 5'h10;
  localparam logic [4:0] EW_RX1 = 5'h11;
  localparam logic [4:0] EW_CFG0 = 5'h12;
  localparam logic [4:0] EW_CFG5 = 5'h17;

  // Transmit events from the frame engine, one bit per buffer
  typedef struct packed {
    logic [2:0] done;
    logic [2:0] aborted;
    logic [2:0] arbLost;
    logic [2:0] busErr;
  } cmst_txev_t;

  // Decoded access window
  typedef struct packed {
    logic [2:0] kind;
    logic [2:0] index;
  } cmst_win_t;

  // Whole block state
  typedef struct packed {
    logic [2:0] reqMode;
    logic [2:0] legMap;
    logic [1:0] modeSel;
    logic wm;
    logic [4:0] extMap;
    logic [2:0] operating_mode_status;
    logic ovf0;
    logic ovf1;
    logic [2:0] txDone;
    logic [2:0] tx_aborted_status;
    logic [2:0] tx_arbitration_lost_status;
    logic [2:0] tx_bus_fault_status;
    logic [2:0] tx_send_request;
    logic [2:0] txAbortReq;
    logic [5:0] tx_buffer_priority;
    logic txSelValid;
    logic [1:0] txSel;
    cmst_win_t legacy_map_select;
    logic [31:0] rdata;
    logic slverr;
  } cmst_state_t;
endpackage

// File: testbench/cmst_engine_model.sv
// Frame engine stand-in: answers the block's transmit selection.
// Assumes the bench drives hold and resp by hierarchical access; lat stays at 3.
`timescale 1ns/10ps

module cmst_engine_model
  import cmst_pkg::*;
(
  // Clock
  input wire logic clk,
  // Selection from the block
  input wire logic txSelValid,
  input wire logic [1:0] txSelect,
  input wire logic [2:0] txAbortRequest,
  // Event pulses back
  output cmst_txev_t txEvents
);
  logic hold = 1'b1;
  logic [1:0] resp = 2'h0;
  int lat = 3;
  int cnt = 0;
  logic [1:0] order[$];

  // Abort wins; else send the selected buffer after lat cycles
  always @(posedge clk) begin
    txEvents <= '0;
    if (|txAbortRequest) begin
      txEvents.aborted <= txAbortRequest;
    end else if (hold || !txSelValid) begin
      cnt <= 0;
    end else if (cnt < lat) begin
      cnt <= cnt + 1;
    end else begin
      cnt <= 0;
      if (resp == 2'h0) begin
        txEvents.done[txSelect] <= 1'b1;
        order.push_back(txSelect);
      end else if (resp == 2'h1) begin
        txEvents.arbLost[txSelect] <= 1'b1;
      end else begin
        txEvents.busErr[txSelect] <= 1'b1;
      end
    end
  end
endmodule // cmst_engine_model

// File: testbench/cmst_ctrl_tb_top.sv
// Self-checking bench for the CAN mode, status and transmit control.
// Assumes cmst_pkg, cmst_ctrl and cmst_engine_model compiled before it.
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end

module cmst_ctrl_tb_top import cmst_pkg::*; ();
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, modeSwitchOk = 1'b1, pready, pslverr, rerr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [8:0] txErrCount = 9'h000;
  logic [7:0] rxErrCount = 8'h00;
  logic [4:0] code = 5'h00;
  logic [3:0] qCount = 4'h0, qFree = 4'hF;
  logic ovf0 = 1'b0, ovf1 = 1'b0, ovfAny = 1'b0, selValid, rxQueueIrq;
  logic [2:0] operatingModeStatus, txPending, txAbortRequest;
  logic [1:0] functionalModeSelect, txSelect;
  cmst_txev_t tev;
  cmst_win_t accessWindow;
  int bad_count = 0, checked = 0;

  // Clock, 100 MHz
  always #5 clk = ~clk;

  cmst_ctrl u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modeSwitchOk(modeSwitchOk), .txErrCount(txErrCount),
    .rxErrCount(rxErrCount), .interruptSourceCode(code),
    .rxQueueCount(qCount), .rxQueueFree(qFree), .rxOverrun0(ovf0),
    .rxOverrun1(ovf1), .rxOverrunAny(ovfAny), .txEvents(tev),
    .operatingModeStatus(operatingModeStatus),
    .functionalModeSelect(functionalModeSelect), .txPending(txPending),
    .txAbortRequest(txAbortRequest), .txSelValid(selValid),
    .txSelect(txSelect), .rxQueueIrq(rxQueueIrq),
    .accessWindow(accessWindow));

  cmst_engine_model u_model (.clk(clk), .txSelValid(selValid),
    .txSelect(txSelect), .txAbortRequest(txAbortRequest), .txEvents(tev));

  // One APB transfer; read data and error taken at the ready edge
  task automatic ap(input logic w, input logic [11:0] a,
                    input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e,
                    input string nm);
    ap(1'b0, a, 8'h00);
    `CHK(nm, {24'h000000, e}, rdat)
  endtask

  // One-cycle event pulse on an engine input
  task automatic pulse(input int k);
    @(posedge clk);
    {ovfAny, ovf1, ovf0} <= 3'h1 << k;
    @(posedge clk);
    {ovfAny, ovf1, ovf0} <= 3'h0;
  endtask

  task automatic wait_idle();
    for (int n = 0; n < 300 && txPending !== 3'h0; n++) @(posedge clk);
    `CHK("idle", 3'h0, txPending)
  endtask

  task automatic t_reset();
    `CHK("operating_mode_status", OPM_CONFIG, operatingModeStatus)
    `CHK("fmode", FM_LEGACY, functionalModeSelect)
    rd(ADDR_STAT, 8'h80, "status");
    rd(ADDR_MAPCTL, 8'h00, "mapctl");
    rd(ADDR_COMMUNICATION_ERROR_STATUS, 8'h00, "communication_error_status");
    rd(ADDR_TXCON2, 8'h00, "txcon");
    rd(12'h040, 8'h00, "unmapped");
    `CHK("slverr", 1'b1, rerr)
    $display("test reset done");
  endtask

  task automatic t_legacy();
    code <= 5'h0A;
    ap(1'b1, ADDR_CTRL, 8'h88);
    rd(ADDR_CTRL, 8'h88, "ctrl");
    `CHK("legwin", 6'o10, accessWindow)
    rd(ADDR_STAT, 8'h8A, "code");
    ap(1'b1, ADDR_MAPCTL, 8'h03);
    rd(ADDR_MAPCTL, 8'h00, "ext0");
    pulse(0);
    rd(ADDR_COMMUNICATION_ERROR_STATUS, 8'h80, "ovf0");
    pulse(1);
    rd(ADDR_COMMUNICATION_ERROR_STATUS, 8'hC0, "ovf1");
    ap(1'b1, ADDR_COMMUNICATION_ERROR_STATUS, 8'h00);
    rd(ADDR_COMMUNICATION_ERROR_STATUS, 8'h00, "ovfclr");
    $display("test legacy done");
  endtask

  task automatic t_errs();
    logic [8:0] tv[7] = '{9'd95, 9'd96, 9'd127, 9'd128, 9'd255, 9'd256, 9'd511};
    logic [7:0] rv[7] = '{8'd95, 8'd96, 8'd127, 8'd128, 8'd200, 8'd0, 8'd255};
    logic [7:0] e;
    for (int i = 0; i < 7; i++) begin
      txErrCount <= tv[i];
      rxErrCount <= rv[i];
      e = 8'h00;
      e[5] = tv[i] > 9'd255;
      e[4] = tv[i] > 9'd127;
      e[3] = rv[i] > 8'd127;
      e[2] = tv[i] > 9'd95;
      e[1] = rv[i] > 8'd95 && rv[i] <= 8'd127;
      e[0] = e[2] | e[1];
      rd(ADDR_COMMUNICATION_ERROR_STATUS, e, "errs");
    end
    txErrCount <= 9'h000;
    rxErrCount <= 8'h00;
    $display("test errors done");
  endtask

  task automatic t_mode();
    logic [4:0] ev[5] = '{5'h03, 5'h05, 5'h11, 5'h12, 5'h17};
    logic [5:0] wv[5] = '{6'o10, 6'o12, 6'o21, 6'o30, 6'o35};
    ap(1'b1, ADDR_MAPCTL, 8'hD0);
    @(posedge clk);
    `CHK("fm11", FM_LEGACY, functionalModeSelect)
    ap(1'b1, ADDR_MAPCTL, 8'h43);
    qCount <= 4'h2;
    rd(ADDR_COMMUNICATION_ERROR_STATUS, 8'h00, "mode1");
    for (int i = 0; i < 5; i++) begin
      ap(1'b1, ADDR_MAPCTL, {3'b100, ev[i]});
      rd(ADDR_MAPCTL, {3'b100, ev[i]}, "extmap");
      `CHK("window", wv[i], accessWindow)
    end
    ap(1'b1, ADDR_MAPCTL, 8'h8F);
    rd(ADDR_MAPCTL, 8'h8F, "rxint");
    `CHK("rxintwin", WK_RXINT, accessWindow.kind)
    `CHK("fm2", FM_ENH_QUEUE, functionalModeSelect)
    qCount <= 4'h2;
    pulse(2);
    rd(ADDR_COMMUNICATION_ERROR_STATUS, 8'hC0, "queue");
    ap(1'b1, ADDR_COMMUNICATION_ERROR_STATUS, 8'h80);
    qCount <= 4'h0;
    rd(ADDR_COMMUNICATION_ERROR_STATUS, 8'h00, "empty");
    ap(1'b1, ADDR_MAPCTL, 8'h90);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) ap(1'b1, ADDR_MAPCTL, 8'hB0);
      qFree <= (i < 2) ? 4'h4 + i[3:0] : i[3:0] - 4'h1;
      repeat (2) @(posedge clk);
      `CHK("irq", i[0] ? 1'b0 : 1'b1, rxQueueIrq)
    end
    $display("test mode done");
  endtask

  task automatic t_normal();
    code <= 5'h11;
    ap(1'b1, ADDR_CTRL, 8'h00);
    rd(ADDR_STAT, 8'h11, "stat2");
    `CHK("opnorm", OPM_NORMAL, operatingModeStatus)
    ap(1'b1, ADDR_MAPCTL, 8'h50);
    rd(ADDR_MAPCTL, 8'h90, "lock");
    $display("test normal done");
  endtask

  task automatic t_prio();
    logic [5:0] ord;
    ap(1'b1, ADDR_TXCON0, 8'h0B);
    ap(1'b1, ADDR_TXCON1, 8'h09);
    ap(1'b1, ADDR_TXCON2, 8'h09);
    @(posedge clk);
    `CHK("pend", 3'h7, txPending)
    u_model.hold <= 1'b0;
    wait_idle();
    `CHK("nsent", 3, u_model.order.size())
    ord = {u_model.order[0], u_model.order[1], u_model.order[2]};
    `CHK("order", 6'b001001, ord)
    rd(ADDR_TXCON0, 8'h83, "done");
    ap(1'b1, ADDR_TXCON0, 8'h01);
    rd(ADDR_TXCON0, 8'h01, "doneclr");
    $display("test priority done");
  endtask

  task automatic t_abort();
    logic [7:0] e;
    ap(1'b1, ADDR_TXCON1, 8'h01);
    for (int r = 1; r < 3; r++) begin
      u_model.hold <= 1'b1;
      u_model.resp <= r[1:0];
      ap(1'b1, ADDR_TXCON1, 8'h0A);
      u_model.hold <= 1'b0;
      for (int n = 0; n < 50 && !(|tev.arbLost || |tev.busErr); n++)
        @(posedge clk);
      u_model.hold <= 1'b1;
      e = (r == 1) ? 8'h2A : 8'h1A;
      rd(ADDR_TXCON1, e, "fault");
      ap(1'b1, ADDR_TXCON1, 8'h0B);
      rd(ADDR_TXCON1, e, "locked");
      ap(1'b1, ADDR_TXCON1, 8'h02);
      repeat (2) @(posedge clk);
      rd(ADDR_TXCON1, (e & 8'hF7) | 8'h40, "abort");
      ap(1'b1, ADDR_TXCON1, 8'h0A);
      rd(ADDR_TXCON1, 8'h0A, "rereq");
    end
    u_model.resp <= 2'h0;
    u_model.hold <= 1'b0;
    wait_idle();
    rd(ADDR_TXCON1, 8'h82, "sent");
    $display("test abort done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_legacy();
    t_errs();
    t_mode();
    t_normal();
    t_prio();
    t_abort();
    print_verdict();
  end
endmodule // cmst_ctrl_tb_top
